// file: bus_pattern_checker.sv
// Cyclic comparison of received words against the programmed pattern.
// Assumes inputs synchronous to clk and a restart pulse on each strobe rising edge.
module bus_pattern_checker #(
    parameter int WIDTH = 14,
    parameter int WORDS = 8
) (
    // Clock, reset and enable
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   ce,
    // Control
    input  wire logic                   test_enable,
    input  wire logic                   clear_errors,
    input  wire logic                   restart,
    // Received word
    input  wire logic [WIDTH-1:0]       word_in,
    input  wire logic                   word_valid,
    // Expected pattern, word k at bits k*WIDTH
    input  wire logic [WORDS*WIDTH-1:0] expected,
    // Results
    output logic      [WIDTH-1:0]       error_bits,
    output logic      [$clog2(WORDS)-1:0] word_index
);
    localparam int IW = $clog2(WORDS);

    logic [IW-1:0]    index_reg;
    logic [IW-1:0]    index_next;
    logic [IW-1:0]    index_used;
    logic [IW-1:0]    index_inc;
    logic [WIDTH-1:0] expected_word;
    logic [WIDTH-1:0] mismatch;
    logic [WIDTH-1:0] errors_reg;
    logic [WIDTH-1:0] errors_next;

    // Strobe edge forces word zero, then step and wrap
    assign index_used    = restart ? '0 : index_reg;
    assign index_inc     = (index_used == IW'(WORDS - 1)) ? '0 : index_used + 1'b1;
    assign index_next    = !test_enable ? '0 : (word_valid ? index_inc : index_used);
    assign expected_word = expected[index_used*WIDTH +: WIDTH];

    // Bad bits accumulate; a new mismatch beats a clear in the same cycle
    assign mismatch    = (test_enable && word_valid) ? (word_in ^ expected_word) : '0;
    assign errors_next = (clear_errors ? '0 : errors_reg) | mismatch;

    // State update
    always_ff @(posedge clk) begin
        if (reset) begin
            index_reg  <= '0;
            errors_reg <= '0;
        end else if (ce) begin
            index_reg  <= index_next;
            errors_reg <= errors_next;
        end
    end

    assign error_bits = errors_reg;
    assign word_index = index_reg;

endmodule

// file: dac_pattern_bank.sv
// Pattern registers, static override and input bus check of a dual converter.
// Assumes an Avalon-MM master with byte addresses and a word-interleaved input bus.
//
// Local design decision: the Avalon-MM interface to the registers.
`include "dac_test_defines.svh"

module dac_pattern_bank
    import dac_test_pkg::*;
#(
    parameter int DATA_WIDTH = 14,
    parameter int WORDS      = 8
) (
    // Clock, reset and enable
    input  wire logic                  CLK,
    input  wire logic                  RESET,
    input  wire logic                  CE,
    // Avalon-MM slave
    input  wire logic [8:0]            ADDRESS,
    input  wire logic                  READ,
    input  wire logic                  WRITE,
    input  wire logic [31:0]           WRITEDATA,
    input  wire logic [3:0]            BYTEENABLE,
    output logic      [31:0]           READDATA,
    output logic                       WAITREQUEST,
    // Input data bus, channel A word then channel B word
    input  wire logic [DATA_WIDTH-1:0] DATA_IN,
    input  wire logic                  DATA_VALID,
    input  wire logic                  FRAME_STROBE,
    // Converter codes
    output logic      [DATA_WIDTH-1:0] DAC_A_CODE,
    output logic      [DATA_WIDTH-1:0] DAC_B_CODE,
    // Test result summary
    output logic                       CHECK_ERROR
);
    localparam int IW = $clog2(WORDS);

    // Bus state
    bus_state_e              bus_state_reg;
    bus_state_e              bus_state_next;
    logic [31:0]             readdata_reg;
    logic [31:0]             readdata_next;
    logic                    request;
    logic                    accept;
    logic                    write_accept;
    logic                    aligned;
    reg_index_t              index;
    logic [15:0]             read_mux;

    // Registers
    logic [DATA_WIDTH-1:0]   word_reg [WORDS];
    logic [DATA_WIDTH-1:0]   word_next [WORDS];
    logic [DATA_WIDTH-1:0]   static_code_reg;
    logic [DATA_WIDTH-1:0]   static_code_next;
    logic                    override_ena_reg;
    logic                    override_ena_next;
    logic                    test_ena_reg;
    logic                    test_ena_next;
    logic [15:0]             merged_word;
    logic [15:0]             merged_static;
    logic                    hit_static;
    logic                    hit_control;
    logic                    hit_status;
    logic                    hit_word;
    logic [IW-1:0]           word_sel;
    logic                    clear_errors;

    // Data path
    logic                    strobe_prev_reg;
    logic                    restart;
    logic                    phase_reg;
    logic                    phase_used;
    logic                    phase_next;
    logic [DATA_WIDTH-1:0]   hold_a_reg;
    logic [DATA_WIDTH-1:0]   hold_a_next;
    logic [DATA_WIDTH-1:0]   dac_a_reg;
    logic [DATA_WIDTH-1:0]   dac_a_next;
    logic [DATA_WIDTH-1:0]   dac_b_reg;
    logic [DATA_WIDTH-1:0]   dac_b_next;
    logic                    word_b;
    logic [WORDS*DATA_WIDTH-1:0] expected_flat;
    logic [DATA_WIDTH-1:0]   error_bits;

    // Reset value of pattern word k
    function automatic logic [DATA_WIDTH-1:0] word_reset(input int k);
        logic [13:0] value;
        value = 14'h0000;
        case (k)
            0: value = `RST_PATTERN_WORD0;
            1: value = `RST_PATTERN_WORD1;
            2: value = `RST_PATTERN_WORD2;
            3: value = `RST_PATTERN_WORD3;
            4: value = `RST_PATTERN_WORD4;
            5: value = `RST_PATTERN_WORD5;
            6: value = `RST_PATTERN_WORD6;
            7: value = `RST_PATTERN_WORD7;
            default: value = 14'h0000;
        endcase
        return DATA_WIDTH'(value);
    endfunction

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] wdata,
                                          input logic [3:0]  be);
        logic [15:0] result;
        result[7:0]  = be[0] ? wdata[7:0]  : old[7:0];
        result[15:8] = be[1] ? wdata[15:8] : old[15:8];
        return result;
    endfunction

    // Address decode; offsets are word indices, byte address is four times
    assign aligned     = (ADDRESS[1:0] == 2'h0);
    assign index       = ADDRESS[8:2];
    assign hit_word    = aligned && (index >= `IDX_PATTERN_WORD0)
                                 && (index <= `IDX_PATTERN_WORD7);
    assign word_sel    = IW'(index - `IDX_PATTERN_WORD0);
    assign hit_static  = aligned && (index == `IDX_STATIC_OVERRIDE);
    assign hit_control = aligned && (index == `IDX_TEST_CONTROL);
    assign hit_status  = aligned && (index == `IDX_TEST_STATUS);

    // Handshake: one wait cycle, then the answer cycle
    assign request        = READ || WRITE;
    assign accept         = request && (bus_state_reg == BUS_ANSWER);
    assign write_accept   = accept && WRITE;
    assign WAITREQUEST    = request && (bus_state_reg != BUS_ANSWER);
    assign bus_state_next = (bus_state_reg == BUS_IDLE && request) ? BUS_ANSWER : BUS_IDLE;

    // Read multiplexer; reserved and unmapped bits read zero
    always_comb begin
        read_mux = 16'h0000;
        if (hit_word) begin
            read_mux[DATA_WIDTH-1:0] = word_reg[word_sel];
        end else if (hit_static) begin
            read_mux[DATA_WIDTH-1:0]       = static_code_reg;
            read_mux[`FLD_OVERRIDE_ENA]    = override_ena_reg;
        end else if (hit_control) begin
            read_mux[`FLD_CTL_TEST_ENA]    = test_ena_reg;
        end else if (hit_status) begin
            read_mux[DATA_WIDTH-1:0]       = error_bits;
            read_mux[`FLD_STS_ANY_ERR]     = |error_bits;
        end
    end

    // Read data captured when the wait cycle ends
    assign readdata_next = (bus_state_reg == BUS_IDLE && READ) ? {16'h0000, read_mux}
                                                               : readdata_reg;

    // Pattern word writes, bits 15:14 dropped
    assign merged_word = merge({2'h0, word_reg[word_sel]}, WRITEDATA, BYTEENABLE);
    always_comb begin
        for (int k = 0; k < WORDS; k++) begin
            word_next[k] = word_reg[k];
            if (write_accept && hit_word && word_sel == IW'(k)) begin
                word_next[k] = merged_word[DATA_WIDTH-1:0];
            end
        end
    end

    // Override register write, bit 14 reserved
    assign merged_static     = merge({override_ena_reg, 1'b0, static_code_reg},
                                     WRITEDATA, BYTEENABLE);
    assign static_code_next  = (write_accept && hit_static) ? merged_static[DATA_WIDTH-1:0]
                                                            : static_code_reg;
    assign override_ena_next = (write_accept && hit_static) ? merged_static[`FLD_OVERRIDE_ENA]
                                                            : override_ena_reg;

    // Test control; clear bit is a write-one pulse
    assign test_ena_next = (write_accept && hit_control && BYTEENABLE[0])
                           ? WRITEDATA[`FLD_CTL_TEST_ENA] : test_ena_reg;
    assign clear_errors  = write_accept && hit_control && BYTEENABLE[0]
                           && WRITEDATA[`FLD_CTL_CLEAR_ERR];

    // Strobe edge restarts the channel phase and the pattern index
    assign restart    = FRAME_STROBE && !strobe_prev_reg;
    assign phase_used = restart ? 1'b0 : phase_reg;
    assign word_b     = DATA_VALID && phase_used;
    assign phase_next = DATA_VALID ? !phase_used : phase_used;
    assign hold_a_next = (DATA_VALID && !phase_used) ? DATA_IN : hold_a_reg;

    // Converter codes: static override wins over the input path
    assign dac_a_next = override_ena_reg ? static_code_reg
                      : (word_b ? hold_a_reg : dac_a_reg);
    assign dac_b_next = override_ena_reg ? static_code_reg
                      : (word_b ? DATA_IN : dac_b_reg);

    // Pattern words flattened for the checker
    genvar g;
    generate
        for (g = 0; g < WORDS; g++) begin : g_flat
            assign expected_flat[g*DATA_WIDTH +: DATA_WIDTH] = word_reg[g];
        end
    endgenerate

    // Input bus comparison
    bus_pattern_checker #(
        .WIDTH (DATA_WIDTH),
        .WORDS (WORDS)
    ) u_checker (
        .clk          (CLK),
        .reset        (RESET),
        .ce           (CE),
        .test_enable  (test_ena_reg),
        .clear_errors (clear_errors),
        .restart      (restart),
        .word_in      (DATA_IN),
        .word_valid   (DATA_VALID),
        .expected     (expected_flat),
        .error_bits   (error_bits),
        .word_index   ()
    );

    // Bus and control registers
    always_ff @(posedge CLK) begin
        if (RESET) begin
            bus_state_reg    <= BUS_IDLE;
            readdata_reg     <= 32'h0000_0000;
            static_code_reg  <= `RST_STATIC_CODE;
            override_ena_reg <= `RST_OVERRIDE_ENA;
            test_ena_reg     <= 1'b0;
        end else if (CE) begin
            bus_state_reg    <= bus_state_next;
            readdata_reg     <= readdata_next;
            static_code_reg  <= static_code_next;
            override_ena_reg <= override_ena_next;
            test_ena_reg     <= test_ena_next;
        end
    end

    // Pattern words
    always_ff @(posedge CLK) begin
        for (int k = 0; k < WORDS; k++) begin
            if (RESET) begin
                word_reg[k] <= word_reset(k);
            end else if (CE) begin
                word_reg[k] <= word_next[k];
            end
        end
    end

    // Data path registers
    always_ff @(posedge CLK) begin
        if (RESET) begin
            strobe_prev_reg <= 1'b0;
            phase_reg       <= 1'b0;
            hold_a_reg      <= '0;
            dac_a_reg       <= '0;
            dac_b_reg       <= '0;
        end else if (CE) begin
            strobe_prev_reg <= FRAME_STROBE;
            phase_reg       <= phase_next;
            hold_a_reg      <= hold_a_next;
            dac_a_reg       <= dac_a_next;
            dac_b_reg       <= dac_b_next;
        end
    end

    assign READDATA    = readdata_reg;
    assign DAC_A_CODE  = dac_a_reg;
    assign DAC_B_CODE  = dac_b_reg;
    assign CHECK_ERROR = |error_bits;

endmodule

// file: dac_pattern_bank_bench.sv
// Bench for the pattern bank: register access, check frames and static override.
// Assumes the design, the bound checker and the source model are compiled first.
`include "dac_test_defines.svh"
module dac_pattern_bank_bench
    import dac_test_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'h0, reset = 1'h1, rd = 1'h0, wr = 1'h0, send = 1'h0, slow = 1'h0;
    logic        ce = 1'h1;
    logic [8:0]  addr = 9'h000;
    logic [31:0] wdata = 32'h0, q, rdata;
    logic [3:0]  be = 4'hF, flip = 4'h8;
    logic        waitreq, dvalid, strobe, chk_err, busy;
    logic [13:0] din, code_a, code_b;
    int          err_total = 0, n_compared = 0;
    wire [111:0] pat_vec = {`RST_PATTERN_WORD7, `RST_PATTERN_WORD6, `RST_PATTERN_WORD5,
        `RST_PATTERN_WORD4, `RST_PATTERN_WORD3, `RST_PATTERN_WORD2, `RST_PATTERN_WORD1,
        `RST_PATTERN_WORD0};
    always #5 clk = ~clk;
    dac_pattern_bank dut (.CLK(clk), .RESET(reset), .CE(ce), .ADDRESS(addr), .READ(rd),
        .WRITE(wr), .WRITEDATA(wdata), .BYTEENABLE(be), .READDATA(rdata), .WAITREQUEST(waitreq),
        .DATA_IN(din), .DATA_VALID(dvalid), .FRAME_STROBE(strobe), .DAC_A_CODE(code_a),
        .DAC_B_CODE(code_b), .CHECK_ERROR(chk_err));
    data_source_model src (.clk(clk), .send(send), .slow(slow), .flip_at(flip),
        .words(pat_vec), .data(din), .valid(dvalid), .strobe(strobe), .busy(busy));
    // Verdict and end of run
    task automatic stop_test();
        if (err_total == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One Avalon transfer, held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [8:0] a, input logic [15:0] d,
                       input logic [3:0] b);
        int n;
        @(posedge clk);
        addr  <= a;
        wr    <= w;
        rd    <= !w;
        wdata <= {16'h0000, d};
        be    <= b;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'h0 && n < 20);
        if (n >= 20) begin
            err_total++;
            stop_test();
        end
        q = rdata;
        rd <= 1'h0;
        wr <= 1'h0;
    endtask
    task automatic rchk(input logic [8:0] a, input logic [31:0] exp);
        bus(1'h0, a, 16'h0000, 4'hF);
        chk($sformatf("reg %h", a), exp, q);
    endtask
    task automatic cchk(input logic [13:0] ea, input logic [13:0] eb, input logic e);
        chk("code a", {18'h00000, ea}, {18'h00000, code_a});
        chk("code b", {18'h00000, eb}, {18'h00000, code_b});
        chk("error flag", {31'h0, e}, {31'h0, chk_err});
    endtask
    // Frame from the source, waited for under a bound
    task automatic frame(input logic s, input logic [3:0] f);
        int n;
        @(posedge clk);
        slow <= s;
        flip <= f;
        send <= 1'h1;
        @(posedge clk);
        send <= 1'h0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (busy !== 1'h0 && n < 50);
        if (n >= 50) begin
            err_total++;
            stop_test();
        end
        repeat (3) @(negedge clk);
    endtask
    // Main sequence
    initial begin
        logic [8:0] a;
        repeat (5) @(posedge clk);
        reset <= 1'h0;
        for (int k = 0; k < 8; k++) begin
            a = 9'h030 + 9'(4 * k);
            rchk(a, 32'(pat_vec[k*14 +: 14]));
            bus(1'h1, a, 16'hFFFF, 4'hF);
            bus(1'h1, a, 16'h0000, 4'h1);
            rchk(a, 32'h0000_3F00);
            bus(1'h1, a, {2'h0, pat_vec[k*14 +: 14]}, 4'hF);
        end
        rchk(9'h050, 32'h0000_0000);
        rchk(9'h154, 32'h0000_0000);
        bus(1'h1, 9'h039, 16'h0000, 4'hF);
        rchk(9'h038, {18'h00000, pat_vec[28 +: 14]});
        bus(1'h1, 9'h080, 16'h0001, 4'hF);
        rchk(9'h080, 32'h0000_0001);
        frame(1'h0, 4'h8);
        cchk(pat_vec[84 +: 14], pat_vec[98 +: 14], 1'h0);
        frame(1'h1, 4'h8);
        cchk(pat_vec[84 +: 14], pat_vec[98 +: 14], 1'h0);
        frame(1'h0, 4'h3);
        chk("error flag", 32'h1, {31'h0, chk_err});
        rchk(9'h084, 32'h0000_8001);
        bus(1'h1, 9'h080, 16'h0003, 4'hF);
        rchk(9'h084, 32'h0000_0000);
        frame(1'h0, 4'h8);
        cchk(pat_vec[84 +: 14], pat_vec[98 +: 14], 1'h0);
        bus(1'h1, 9'h050, 16'hD234, 4'hF);
        repeat (3) @(negedge clk);
        cchk(14'h1234, 14'h1234, 1'h0);
        rchk(9'h050, 32'h0000_9234);
        frame(1'h0, 4'h8);
        cchk(14'h1234, 14'h1234, 1'h0);
        bus(1'h1, 9'h050, 16'h1234, 4'hF);
        frame(1'h0, 4'h8);
        cchk(pat_vec[84 +: 14], pat_vec[98 +: 14], 1'h0);
        // Clock enable low: a frame with a bad word must leave no trace
        @(posedge clk);
        ce <= 1'h0;
        frame(1'h0, 4'h3);
        cchk(pat_vec[84 +: 14], pat_vec[98 +: 14], 1'h0);
        @(posedge clk);
        ce <= 1'h1;
        stop_test();
    end
endmodule

// file: dac_pattern_bank_monitor.sv
// Checker for the pattern bank: bus wait, register contents, converter codes, error flag.
// Assumes it is bound to dac_pattern_bank and sees only that module's ports.
`include "dac_test_defines.svh"
module dac_pattern_bank_monitor
    import dac_test_pkg::*;
#(
    parameter int DATA_WIDTH = 14
) (
    // Clock, reset and enable
    input wire logic                  CLK,
    input wire logic                  RESET,
    input wire logic                  CE,
    // Register bus
    input wire logic [8:0]            ADDRESS,
    input wire logic                  READ,
    input wire logic                  WRITE,
    input wire logic [31:0]           WRITEDATA,
    input wire logic [3:0]            BYTEENABLE,
    input wire logic [31:0]           READDATA,
    input wire logic                  WAITREQUEST,
    // Input bus
    input wire logic [DATA_WIDTH-1:0] DATA_IN,
    input wire logic                  DATA_VALID,
    input wire logic                  FRAME_STROBE,
    // Outputs
    input wire logic [DATA_WIDTH-1:0] DAC_A_CODE,
    input wire logic [DATA_WIDTH-1:0] DAC_B_CODE,
    input wire logic                  CHECK_ERROR
);
    reg_index_t  idx;
    logic [13:0] pat_reg [8];
    logic [13:0] code_reg;
    logic        ovr_reg;
    logic        ten_reg;
    // Decode of accepted transfers
    assign idx = ADDRESS[8:2];
    wire         acc    = CE && !WAITREQUEST && ADDRESS[1:0] == 2'h0;
    wire         wr_ok  = acc && WRITE;
    wire         rd_ok  = acc && READ;
    wire         is_pat = idx >= `IDX_PATTERN_WORD0 && idx <= `IDX_PATTERN_WORD7;
    wire         is_ovr = idx == `IDX_STATIC_OVERRIDE;
    wire         is_ctl = idx == `IDX_TEST_CONTROL;
    wire [2:0]   pidx   = 3'(idx - `IDX_PATTERN_WORD0);
    wire         clr_wr = wr_ok && is_ctl && BYTEENABLE[0] && WRITEDATA[`FLD_CTL_CLEAR_ERR];
    wire [111:0] rst_pat = {`RST_PATTERN_WORD7, `RST_PATTERN_WORD6, `RST_PATTERN_WORD5,
        `RST_PATTERN_WORD4, `RST_PATTERN_WORD3, `RST_PATTERN_WORD2, `RST_PATTERN_WORD1,
        `RST_PATTERN_WORD0};
    // Mirror of the writable registers; reset acts as in the design
    always_ff @(posedge CLK) begin
        if (RESET) begin
            for (int k = 0; k < 8; k++) pat_reg[k] <= rst_pat[k*14 +: 14];
            code_reg <= `RST_STATIC_CODE;
            ovr_reg  <= `RST_OVERRIDE_ENA;
            ten_reg  <= 1'h0;
        end else if (wr_ok) begin
            if (is_pat && BYTEENABLE[0]) pat_reg[pidx][7:0] <= WRITEDATA[7:0];
            if (is_pat && BYTEENABLE[1]) pat_reg[pidx][13:8] <= WRITEDATA[13:8];
            if (is_ovr && BYTEENABLE[0]) code_reg[7:0] <= WRITEDATA[7:0];
            if (is_ovr && BYTEENABLE[1]) begin
                ovr_reg        <= WRITEDATA[`FLD_OVERRIDE_ENA];
                code_reg[13:8] <= WRITEDATA[13:8];
            end
            if (is_ctl && BYTEENABLE[0]) ten_reg <= WRITEDATA[`FLD_CTL_TEST_ENA];
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    // Override armed by a full write with the enable set
    sequence ovr_arm;
        wr_ok && is_ovr && BYTEENABLE[1:0] == 2'h3 && WRITEDATA[15];
    endsequence
    sequence ovr_shown;
        CE ##1 (DAC_A_CODE == $past(WRITEDATA[13:0], 2)
                && DAC_B_CODE == $past(WRITEDATA[13:0], 2));
    endsequence
    bus_wait_a: assert property ($rose(READ || WRITE) && CE |-> WAITREQUEST ##1 !WAITREQUEST)
        else $error("bus wait not one cycle");
    pattern_read_a: assert property (
        rd_ok && is_pat |-> READDATA == {18'h00000, pat_reg[pidx]})
        else $error("pattern word read wrong");
    override_read_a: assert property (
        rd_ok && is_ovr |-> READDATA == {16'h0000, ovr_reg, 1'h0, code_reg})
        else $error("override register read wrong");
    unmapped_zero_a: assert property (
        rd_ok && !is_pat && !is_ovr && !is_ctl && idx != `IDX_TEST_STATUS |-> READDATA == 32'h0)
        else $error("unmapped read not zero");
    override_load_a: assert property (ovr_arm |=> ovr_shown)
        else $error("static code not loaded");
    both_codes_a: assert property (
        ovr_reg && $past(ovr_reg) && $stable(code_reg)
        |-> DAC_A_CODE == code_reg && DAC_B_CODE == code_reg)
        else $error("channels differ from static code");
    codes_hold_a: assert property (
        CE && !DATA_VALID && !ovr_reg |=> $stable(DAC_A_CODE) && $stable(DAC_B_CODE))
        else $error("codes moved without data");
    error_sticky_a: assert property (CE && CHECK_ERROR && !clr_wr |=> CHECK_ERROR)
        else $error("error flag lost");
    quiet_off_a: assert property (CE && !ten_reg && !CHECK_ERROR |=> !CHECK_ERROR)
        else $error("error raised while test off");
endmodule

bind dac_pattern_bank dac_pattern_bank_monitor #(.DATA_WIDTH(DATA_WIDTH)) mon (
    .CLK(CLK), .RESET(RESET), .CE(CE), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
    .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .DATA_IN(DATA_IN), .DATA_VALID(DATA_VALID),
    .FRAME_STROBE(FRAME_STROBE), .DAC_A_CODE(DAC_A_CODE), .DAC_B_CODE(DAC_B_CODE),
    .CHECK_ERROR(CHECK_ERROR));

// file: dac_test_defines.svh
// Offsets, field positions, reset values and bus timing for the pattern bank.
// Assumes a 32-bit Avalon-MM slave; register index times four is the byte address.
`ifndef DAC_TEST_DEFINES_SVH
`define DAC_TEST_DEFINES_SVH

// Register indices
`define IDX_PATTERN_WORD0   7'h0C
`define IDX_PATTERN_WORD1   7'h0D
`define IDX_PATTERN_WORD2   7'h0E
`define IDX_PATTERN_WORD3   7'h0F
`define IDX_PATTERN_WORD4   7'h10
`define IDX_PATTERN_WORD5   7'h11
`define IDX_PATTERN_WORD6   7'h12
`define IDX_PATTERN_WORD7   7'h13
`define IDX_STATIC_OVERRIDE 7'h14
`define IDX_TEST_CONTROL    7'h20
`define IDX_TEST_STATUS     7'h21

// Reset values
`define RST_PATTERN_WORD0   14'h3A7A
`define RST_PATTERN_WORD1   14'h36B6
`define RST_PATTERN_WORD2   14'h2AEA
`define RST_PATTERN_WORD3   14'h0545
`define RST_PATTERN_WORD4   14'h0585
`define RST_PATTERN_WORD5   14'h0949
`define RST_PATTERN_WORD6   14'h1515
`define RST_PATTERN_WORD7   14'h3ABA
`define RST_STATIC_CODE     14'h0000
`define RST_OVERRIDE_ENA    1'b0

// Field positions
`define FLD_OVERRIDE_ENA    15
`define FLD_CTL_TEST_ENA    0
`define FLD_CTL_CLEAR_ERR   1
`define FLD_STS_ANY_ERR     15

// Number of wait cycles the slave holds waitrequest high
`define BUS_WAIT_CYCLES     1

`endif

// file: dac_test_pkg.sv
// Types shared by the pattern bank and its checker.
// Assumes dac_test_defines.svh supplies the numeric constants.
package dac_test_pkg;

    // Word index of the register map
    typedef logic [6:0] reg_index_t;

    // Bus slave sequence
    typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_e;

endpackage

// file: data_source_model.sv
// Upstream source model: sends the eight-word check sequence on the input bus.
// Assumes one clock; the bench pulses send only while the model is idle.
module data_source_model (
    // Clock and control
    input  wire logic         clk,
    input  wire logic         send,
    input  wire logic         slow,
    input  wire logic [3:0]   flip_at,
    input  wire logic [111:0] words,
    // Input bus
    output logic      [13:0]  data = 14'h0000,
    output logic              valid = 1'h0,
    output logic              strobe = 1'h0,
    output logic              busy = 1'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt = 4'h0;
    logic       gap = 1'h0;
    // One word a cycle, or every other cycle when slow
    always @(posedge clk) begin
        gap <= ~gap;
        if (send && !busy) begin
            busy <= 1'h1;
            cnt  <= 4'h0;
        end else if (busy && (!slow || gap)) begin
            data   <= words[cnt[2:0]*14 +: 14] ^ {13'h0000, cnt == flip_at}; // Commanded bad bit
            valid  <= 1'h1;
            strobe <= cnt == 4'h0;
            busy   <= cnt != 4'h7;
            cnt    <= cnt + 4'h1;
        end else begin
            data   <= ~data; // Released bus toggles between the inverted and the stale last word
            valid  <= 1'h0;
            strobe <= 1'h0;
        end
    end
endmodule
